// ### srag_top.sv
/*
 * stack-relative operand decoder: spots the prefix byte, decodes the
 * following opcode as its index-relative twin, gathers the offset
 * bytes and forms the effective address from the stack pointer.
 * assumes fetched bytes arrive in order, one per accepted cycle, and
 * that stack_pointer_reg is steady while the last offset byte arrives.
 */
// Functional notes
// RL1 - short stack mode is three bytes: prefix, opcode, one unsigned offset
// RL2 - short address is stack pointer plus zero-extended offset byte
// RL3 - each stack form takes one cycle more than its index twin
// RL4 - long stack mode is four bytes: prefix, opcode, two offset bytes
// RL5 - long address is stack pointer plus the 16-bit offset word
// RL6 - opcode part is prefix then opcode; offset starts at byte three
// RL7 - accumulator and index-low operations accept short and long offsets
// RL8 - read-modify-write, branch-on-memory and test accept short offset only
// RL9 - logical left shift is the arithmetic left shift, one encoding
// RL10 - long offset: first byte is high, second byte is low
// RL11 - one fixed prefix selects stack form of the index opcode
// RL12 - address sum wraps modulo 65536
`timescale 1ns/100ps
`default_nettype none
`include "srag_map.svh"

module srag_top
  import srag_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // fetched instruction bytes
  input  wire logic        fetch_valid,
  input  wire logic [7:0]  fetch_byte,
  // stack pointer of the core
  input  wire logic [15:0] stack_pointer_reg,
  // decoded result
  output logic             ea_valid,
  output logic [15:0]      ea,
  output logic [7:0]       ea_op,
  output srag_class_t      ea_class,
  output logic             ea_long,
  output logic [2:0]       inst_len,
  output logic [3:0]       cycle_count,
  output logic             illegal,
  output logic             busy
);

  // ****************************************************************
  // decode
  // ****************************************************************
  srag_state_t state;
  srag_class_t dec_class;
  logic        dec_long;
  logic [3:0]  dec_cycles;
  logic        byte_ok;
  logic [7:0]  hi_byte;
  logic [15:0] offset_cur;

  assign byte_ok = ce & fetch_valid;
  assign busy    = (state != SRAG_IDLE);

  // opcode column picks offset size, row picks the operation;
  // both shift-left names share one row so nothing tells them apart
  always_comb
  begin
    dec_class  = SRAG_CL_NONE;
    dec_long   = 1'b0;
    dec_cycles = `SRAG_CYC_ALU1;
    unique case (fetch_byte[7:4])
      `SRAG_COL_ALU1:
      begin
        if (fetch_byte[3:0] != `SRAG_ROW_JMP && fetch_byte[3:0] != `SRAG_ROW_JSR)
          dec_class = SRAG_CL_ALU;  // [RL7] [RL11]
        dec_cycles = `SRAG_CYC_ALU1;
      end
      `SRAG_COL_ALU2:
      begin
        if (fetch_byte[3:0] != `SRAG_ROW_JMP && fetch_byte[3:0] != `SRAG_ROW_JSR)
          dec_class = SRAG_CL_ALU;  // [RL7]
        dec_long   = 1'b1;
        dec_cycles = `SRAG_CYC_ALU2;
      end
      `SRAG_COL_RMW1:
      begin
        unique case (fetch_byte[3:0])
          `SRAG_ROW_GAP_A, `SRAG_ROW_GAP_B, `SRAG_ROW_GAP_C:
            dec_class = SRAG_CL_NONE;
          `SRAG_ROW_CMPBR, `SRAG_ROW_DECBR:
          begin
            dec_class  = SRAG_CL_BRANCH;  // [RL8]
            dec_cycles = `SRAG_CYC_BR1;
          end
          `SRAG_ROW_TEST:
          begin
            dec_class  = SRAG_CL_TEST;  // [RL8]
            dec_cycles = `SRAG_CYC_TEST1;
          end
          default:
          begin
            dec_class  = SRAG_CL_RMW;  // [RL8] [RL9]
            dec_cycles = `SRAG_CYC_RMW1;
          end
        endcase
      end
      default:
        dec_class = SRAG_CL_NONE;
    endcase
  end

  // ****************************************************************
  // sequence
  // ****************************************************************
  // byte order prefix, opcode, then offset from the third byte on
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= SRAG_IDLE;
    else if (byte_ok)
    begin
      unique case (state)
        SRAG_IDLE:
          if (fetch_byte == `SRAG_PREFIX)
            state <= SRAG_OPC;  // [RL11] [RL6]
        SRAG_OPC:
          if (dec_class == SRAG_CL_NONE)
            state <= SRAG_IDLE;
          else if (dec_long)
            state <= SRAG_OFS_HI;  // [RL4]
          else
            state <= SRAG_OFS_LO;  // [RL1]
        SRAG_OFS_HI:
          state <= SRAG_OFS_LO;
        SRAG_OFS_LO:
          state <= SRAG_IDLE;
      endcase
    end
  end

  // opcode details held until the offset is complete
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ea_op       <= 8'h00;
      ea_class    <= SRAG_CL_NONE;
      ea_long     <= 1'b0;
      inst_len    <= 3'd0;
      cycle_count <= 4'd0;
    end
    else if (byte_ok && state == SRAG_OPC && dec_class != SRAG_CL_NONE)
    begin
      ea_op       <= fetch_byte;  // index twin code
      ea_class    <= dec_class;
      ea_long     <= dec_long;
      inst_len    <= dec_long ? `SRAG_LEN_LONG : `SRAG_LEN_SHORT;  // [RL1] [RL4]
      cycle_count <= dec_cycles + `SRAG_CYC_PREFIX;  // [RL3]
    end
  end

  // first offset byte of a long form is the high half
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      hi_byte <= 8'h00;
    else if (byte_ok && state == SRAG_OFS_HI)
      hi_byte <= fetch_byte;  // [RL10]
  end

  // ****************************************************************
  // address
  // ****************************************************************
  srag_ea_if ea_bus ();

  // short offset is zero-extended, never sign-extended
  assign offset_cur    = ea_long ? {hi_byte, fetch_byte}
                                 : {`SRAG_ZERO_BYTE, fetch_byte};  // [RL2] [RL5] [RL10]
  assign ea_bus.base   = stack_pointer_reg;
  assign ea_bus.offset = offset_cur;

  srag_ea_adder #(
    .AW (16)
  ) u_adder (
    .bus (ea_bus.calc)
  );

  // result pulse lasts one enabled cycle; frozen with ce low
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ea_valid <= 1'b0;
      ea       <= 16'h0000;
      illegal  <= 1'b0;
    end
    else if (ce)
    begin
      ea_valid <= fetch_valid && state == SRAG_OFS_LO;
      illegal  <= fetch_valid && state == SRAG_OPC && dec_class == SRAG_CL_NONE;
      if (fetch_valid && state == SRAG_OFS_LO)
        ea <= ea_bus.ea;  // [RL12]
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_short_sum: assert property (  // [RL2]
    ea_valid && !ea_long && $past(byte_ok)
      |-> ea == 16'($past(stack_pointer_reg) + {8'h00, $past(fetch_byte)}))
    else $error("short stack address wrong");
  a_long_sum: assert property (  // [RL5]
    ea_valid && ea_long && $past(byte_ok)
      |-> ea == 16'($past(stack_pointer_reg) + {hi_byte, $past(fetch_byte)}))
    else $error("long stack address wrong");
  a_hi_first: assert property (  // [RL10]
    byte_ok && state == SRAG_OFS_HI ##1 byte_ok && state == SRAG_OFS_LO
      |=> ea_valid && ea[7:0] == 8'(stack_pointer_reg[7:0] + $past(fetch_byte)))
    else $error("high offset byte order wrong");
  a_short_len: assert property (  // [RL1]
    ea_valid && !ea_long |-> inst_len == 3'd3)
    else $error("short length not three");
  a_long_len: assert property (  // [RL4]
    ea_valid && ea_long |-> inst_len == 3'd4 && ea_class == SRAG_CL_ALU)
    else $error("long form length or class wrong");
  a_extra_cycle: assert property (  // [RL3]
    ea_valid && ea_class == SRAG_CL_ALU |-> cycle_count == (ea_long ? 4'd5 : 4'd4))
    else $error("cycle count not one above twin");
  a_prefix_seen: assert property (  // [RL11]
    byte_ok && state == SRAG_IDLE && fetch_byte == 8'h9e |=> state == SRAG_OPC)
    else $error("prefix not recognised");
  a_offset_third: assert property (  // [RL6]
    byte_ok && state == SRAG_OPC && dec_class != SRAG_CL_NONE
      |=> state == SRAG_OFS_HI || state == SRAG_OFS_LO)
    else $error("offset not at third byte");
  a_shift_same: assert property (  // [RL9]
    byte_ok && state == SRAG_OPC && fetch_byte == 8'h68 |=> ea_class == SRAG_CL_RMW)
    else $error("left shift misdecoded");
  a_jump_refused: assert property (  // [RL7]
    byte_ok && state == SRAG_OPC && (fetch_byte[3:0] == 4'hc || fetch_byte[3:0] == 4'hd)
      && (fetch_byte[7:4] == 4'he || fetch_byte[7:4] == 4'hd) |=> illegal ##1 !ea_valid)
    else $error("jump accepted in stack form");
  a_short_only: assert property (  // [RL8]
    byte_ok && state == SRAG_OPC && fetch_byte[7:4] == 4'h6 && dec_class != SRAG_CL_NONE
      |=> !ea_long)
    else $error("memory op took long offset");

  c_short_done: cover property (ea_valid && !ea_long);
  c_long_done:  cover property (ea_valid && ea_long);
  c_illegal:    cover property (illegal);
  c_branch:     cover property (ea_valid && ea_class == SRAG_CL_BRANCH);

endmodule : srag_top

`default_nettype wire

// ### srag_map.svh
/*
 * constants of the stack-relative address generator: prefix byte,
 * opcode columns and rows, instruction lengths and cycle counts.
 * assumes includers decode with these names; the checks in srag_top repeat the raw figures.
 */
`ifndef SRAG_MAP_SVH
`define SRAG_MAP_SVH

// ****************************************************************
// encoding
// ****************************************************************
`define SRAG_PREFIX      8'h9e
`define SRAG_COL_RMW1    4'h6
`define SRAG_COL_ALU2    4'hd
`define SRAG_COL_ALU1    4'he
`define SRAG_ROW_JMP     4'hc
`define SRAG_ROW_JSR     4'hd
`define SRAG_ROW_CMPBR   4'h1
`define SRAG_ROW_GAP_A   4'h2
`define SRAG_ROW_GAP_B   4'h5
`define SRAG_ROW_DECBR   4'hb
`define SRAG_ROW_TEST    4'hd
`define SRAG_ROW_GAP_C   4'he
`define SRAG_ZERO_BYTE   8'h00

// ****************************************************************
// lengths and cycles
// ****************************************************************
`define SRAG_LEN_SHORT   3'd3
`define SRAG_LEN_LONG    3'd4
`define SRAG_CYC_ALU1    4'd3
`define SRAG_CYC_ALU2    4'd4
`define SRAG_CYC_RMW1    4'd4
`define SRAG_CYC_TEST1   4'd3
`define SRAG_CYC_BR1     4'd5
`define SRAG_CYC_PREFIX  4'd1

`endif

// ### srag_pkg.sv
/*
 * types of the stack-relative address generator.
 * assumes nothing of its surroundings.
 */
`default_nettype none

package srag_pkg;

  // decoder sequence
  typedef enum logic [1:0]
  {
    SRAG_IDLE,
    SRAG_OPC,
    SRAG_OFS_HI,
    SRAG_OFS_LO
  } srag_state_t;

  // operand class of the decoded opcode
  typedef enum logic [2:0]
  {
    SRAG_CL_NONE,
    SRAG_CL_ALU,
    SRAG_CL_RMW,
    SRAG_CL_TEST,
    SRAG_CL_BRANCH
  } srag_class_t;

endpackage : srag_pkg

`default_nettype wire

// ### srag_ea_if.sv
/*
 * carrier between the decoder and its address adder.
 * assumes one adder and one user per instance.
 */
`timescale 1ns/100ps
`default_nettype none

interface srag_ea_if;
  logic [15:0] base;
  logic [15:0] offset;
  logic [15:0] ea;

  modport calc (input base, input offset, output ea);
  modport user (output base, output offset, input ea);
endinterface : srag_ea_if

`default_nettype wire

// ### srag_ea_adder.sv
/*
 * effective address adder: base plus unsigned offset, 16-bit wrap.
 * assumes both operands are already zero-extended by the user.
 */
`timescale 1ns/100ps
`default_nettype none

module srag_ea_adder
  import srag_pkg::*;
#(
  parameter int AW = 16
)
(
  // operands and sum
  srag_ea_if.calc bus
);

  logic [AW:0] full_sum;

  // carry out of the top bit is dropped on purpose
  assign full_sum = {1'b0, bus.base} + {1'b0, bus.offset};
  assign bus.ea   = full_sum[AW-1:0];  // [RL12] [RL2] [RL5]

endmodule : srag_ea_adder

`default_nettype wire

// ### srag_mem_model.sv
/*
 * program memory model: hands queued bytes to the fetch port.
 * assumes the bench fills q and drives gap to slow the answers.
 */
`timescale 1ns/100ps
`default_nettype none

module srag_mem_model
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // pacing
  input  wire logic       ce,
  input  wire logic       gap,
  // fetch port
  output var  logic       fetch_valid,
  output var  logic [7:0] fetch_byte
);
  logic [7:0] q[$];
  logic [7:0] last = 8'h00;
  logic       took;
  logic       slow;

  initial fetch_valid = 1'b0;
  initial fetch_byte = 8'h00;

  // a byte is held until taken; an idle bus shows the inverted last byte
  always @(posedge sys_clk)
  begin
    took = fetch_valid && ce;
    slow = gap;
    #1;
    if (!rst_n)
      fetch_valid = 1'b0;
    else
    begin
      if (took)
      begin
        last = q.pop_front();
        fetch_valid = 1'b0;
      end
      if (!fetch_valid && q.size() > 0 && !slow)
        fetch_valid = 1'b1;
    end
    fetch_byte = fetch_valid ? q[0] : ~last;
  end
endmodule : srag_mem_model

`default_nettype wire

// ### stack_relative_address_gen_bench.sv
/*
 * self-checking bench of the stack-relative decoder.
 * assumes srag_top, its package and the memory model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module stack_relative_address_gen_bench
  import srag_pkg::*;
;
  typedef struct packed {logic ill; logic [15:0] ea; logic [7:0] op; logic [2:0] cls;
    logic lng; logic [2:0] len; logic [3:0] cyc;} srag_exp_t;

  logic        sys_clk, rst_n, ce, gap, fetch_valid, ea_valid, ea_long, illegal, busy;
  logic [7:0]  fetch_byte, ea_op, b;
  logic [15:0] stack_pointer_reg, ea;
  logic [2:0]  inst_len;
  logic [3:0]  cycle_count;
  srag_class_t ea_class;
  logic [31:0] seed;
  int          n_fail, tests_run, cyc_n, pace;
  srag_exp_t   expq[$];
  srag_exp_t   mon_e;

  srag_top dut (.sys_clk, .rst_n, .ce, .fetch_valid, .fetch_byte, .stack_pointer_reg,
    .ea_valid, .ea, .ea_op, .ea_class, .ea_long, .inst_len, .cycle_count, .illegal, .busy);
  srag_mem_model mem (.sys_clk, .rst_n, .ce, .gap, .fetch_valid, .fetch_byte);

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // expected decode of one prefixed opcode
  function automatic srag_exp_t expect_of(logic [7:0] op, logic [15:0] ofs, logic [15:0] sp);
    srag_exp_t e;
    logic [3:0] r;
    // column in the high nibble picks the offset size, row in the low nibble the operation
    r = op[3:0];
    e = '0;
    e.op = op;
    e.cls = SRAG_CL_ALU;
    e.len = 3'd3;
    e.cyc = 4'd4;
    e.ea = sp + {8'h00, ofs[7:0]};
    case (op[7:4])
      4'he: e.ill = (r == 4'hc || r == 4'hd);
      4'hd:
      begin
        e.ill = (r == 4'hc || r == 4'hd);
        {e.lng, e.len, e.cyc, e.ea} = {1'b1, 3'd4, 4'd5, sp + ofs};
      end
      4'h6:
      begin
        e.ill = (r == 4'h2 || r == 4'h5 || r == 4'he);
        {e.cls, e.cyc} = {SRAG_CL_RMW, 4'd5};
        if (r == 4'h1 || r == 4'hb)
          {e.cls, e.cyc} = {SRAG_CL_BRANCH, 4'd6};
        if (r == 4'hd)
          {e.cls, e.cyc} = {SRAG_CL_TEST, 4'd4};
      end
      default: e.ill = 1'b1;
    endcase
    return e;
  endfunction : expect_of

  task automatic chk(input logic [15:0] seen, input logic [15:0] want, input string what);
    tests_run++;
    if (seen !== want)
    begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : chk

  // one clock; random pacing only when asked
  task automatic step();
    @(posedge sys_clk);
    #1;
    if (pace != 0)
    begin
      ce = (rnd() % 8) != 0;
      gap = (rnd() % 4) == 0;
    end
  endtask : step

  task automatic drain();
    int k;
    k = 0;
    // the full opcode sweep queues close to six hundred bytes at once
    while ((expq.size() != 0 || busy !== 1'b0) && k < 4000)
    begin
      step();
      k++;
    end
    chk(16'(expq.size()), 16'h0, "result missing");
  endtask : drain

  // sp may only move once the previous instruction is finished
  task automatic issue(input logic [7:0] op, input logic [15:0] ofs, input logic [15:0] sp);
    srag_exp_t e;
    e = expect_of(op, ofs, sp);
    if (sp !== stack_pointer_reg)
      drain();
    stack_pointer_reg = sp;
    mem.q.push_back(8'h9e);
    mem.q.push_back(op);
    if (!e.ill && e.lng)
      mem.q.push_back(ofs[15:8]);
    if (!e.ill)
      mem.q.push_back(ofs[7:0]);
    expq.push_back(e);
  endtask : issue

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  task automatic close_out();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // ****************************************************************
  // result monitor and timeout
  // ****************************************************************
  // a result counts once per enabled cycle
  always @(negedge sys_clk)
    if (rst_n && ce && (ea_valid === 1'b1 || illegal === 1'b1))
      if (expq.size() == 0)
        chk(16'h1, 16'h0, "extra result");
      else
      begin
        mon_e = expq.pop_front();
        chk({15'h0, illegal}, {15'h0, mon_e.ill}, "illegal");
        if (!mon_e.ill)
        begin
          chk(ea, mon_e.ea, "address");
          chk({8'h0, ea_op}, {8'h0, mon_e.op}, "opcode");
          chk({12'h0, ea_long, inst_len}, {12'h0, mon_e.lng, mon_e.len}, "length");
          chk({9'h0, ea_class, cycle_count}, {9'h0, mon_e.cls, mon_e.cyc}, "class");
        end
      end

  always @(posedge sys_clk)
  begin
    cyc_n++;
    if (cyc_n == 40000)
    begin
      n_fail++;
      close_out();
    end
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    {seed, rst_n, ce, gap, stack_pointer_reg, n_fail, tests_run, cyc_n, pace} = '0;
    seed = 32'd29;
    ce = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    issue(8'he7, 16'h0010, 16'h00ff);
    issue(8'hd6, 16'h0250, 16'h00ff);
    drain();
    done("examples");
    // carry out of bit 15 is dropped
    issue(8'he6, 16'h00ff, 16'hffff);
    issue(8'hd6, 16'hffff, 16'hff00);
    issue(8'h68, 16'h0080, 16'hff90);
    drain();
    done("wrap");
    for (int i = 0; i < 256; i++)
      issue(i[7:0], 16'(rnd() >> 8), 16'h1234);
    drain();
    done("sweep");
    // reset in mid-instruction must leave the decoder idle
    mem.q.push_back(8'h9e);
    mem.q.push_back(8'hd6);
    repeat (4) step();
    chk({15'h0, busy}, 16'h1, "busy before reset");
    rst_n = 1'b0;
    #1 chk(ea, 16'h0, "reset address");
    chk({14'h0, busy, ea_valid}, 16'h0, "reset state");
    repeat (2) step();
    mem.q.delete();
    rst_n = 1'b1;
    issue(8'he7, 16'h0010, 16'h00ff);
    drain();
    done("reset");
    pace = 1;
    for (int i = 0; i < 300; i++)
    begin
      b = 8'(rnd() >> 3);
      if (b[1:0] == 2'b00)
        mem.q.push_back(b == 8'h9e ? 8'h00 : b);
      b = 8'(rnd() >> 5);
      // mostly steer the opcode into one of the three stack columns
      if (b[2:0] != 3'd0)
        b[7:4] = b[1] ? 4'h6 : (b[0] ? 4'hd : 4'he);
      issue(b, 16'(rnd() >> 4), (rnd() % 3 == 0) ? 16'(rnd() >> 9) : stack_pointer_reg);
    end
    drain();
    pace = 0;
    done("random");
    close_out();
  end
endmodule : stack_relative_address_gen_bench

`default_nettype wire
